//--- logic/tlt_map.svh
// register offsets, field positions, reset values and codes for line timing
`ifndef TLT_MAP_SVH
`define TLT_MAP_SVH

`define TLT_CMD_SET_DISPLAY   8'hca
`define TLT_CMD_SET_TIMING    8'ha1
`define TLT_CMD_SET_DATA      8'hbc
`define TLT_CMD_START_ADDR    8'h15
`define TLT_CMD_END_ADDR      8'h75

`define TLT_PARAMS_DISPLAY    4'd9
`define TLT_PARAMS_TIMING     4'd7
`define TLT_PARAMS_DATA       4'd1
`define TLT_PARAMS_ADDR       4'd2

`define TLT_OFS_CMD           12'h000
`define TLT_OFS_PARAM         12'h004
`define TLT_OFS_CTRL          12'h008
`define TLT_OFS_STATUS        12'h00c
`define TLT_OFS_SRC_HIZ       12'h010
`define TLT_OFS_LINE_CFG      12'h014
`define TLT_OFS_TIMING0       12'h018
`define TLT_OFS_TIMING1       12'h01c
`define TLT_OFS_DATA_COND     12'h020
`define TLT_OFS_ADDR          12'h024

`define TLT_CTRL_RUN          0
`define TLT_CTRL_PIXCLK       1
`define TLT_CTRL_REG_BOOSTED  2
`define TLT_CTRL_COM_PWR      3

`define TLT_HIZ_EN_BIT        3
`define TLT_GROUP_WIDTH       3

`define TLT_RST_LINE_PERIOD   10'h049
`define TLT_RST_BACK_PORCH    8'h02
`define TLT_RST_FRONT_PORCH   12'h001
`define TLT_RST_SRC_ON        8'h00
`define TLT_RST_SRC_OFF       8'h46
`define TLT_RST_GATE_ON       8'h04
`define TLT_RST_GATE_OFF      8'h44
`define TLT_RST_BOOST         8'h13
`define TLT_RST_SWITCH        8'h09
`define TLT_RST_END_COL       8'haf
`define TLT_RST_END_ROW       8'hdb

`define TLT_MAX_COL           8'haf
`define TLT_MAX_ROW           8'hdb

`endif

//--- logic/tlt_pkg.sv
// types shared by the line timing block
`default_nettype none
package tlt_pkg;
	typedef enum logic [2:0] {
		TLT_IDLE   = 3'b001,
		TLT_PARAMS = 3'b010,
		TLT_IGNORE = 3'b100
	} tlt_cmd_state_type;

	typedef enum logic [1:0] {
		TLT_DRV_SWITCH  = 2'd0,
		TLT_DRV_CENTRAL = 2'd1,
		TLT_DRV_PREBUF  = 2'd2,
		TLT_DRV_BAD     = 2'd3
	} tlt_drive_mode_type;
endpackage : tlt_pkg
`default_nettype wire

//--- logic/tlt_line_gen.sv
// per-line counter and strobe generator
`include "tlt_map.svh"
`default_nettype none
module tlt_line_gen #(
	parameter int CW = 10
) (
	// clock and reset
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// timing tick and setup
	input  wire logic                  tick,
	input  wire logic                  run,
	input  wire logic [CW-1:0]         line_period,
	input  wire logic [7:0]            src_on,
	input  wire logic [7:0]            src_off,
	input  wire logic [7:0]            gate_on,
	input  wire logic [7:0]            gate_off,
	input  wire logic [7:0]            boost_at,
	input  wire logic [7:0]            switch_at,
	input  wire tlt_pkg::tlt_drive_mode_type drive_mode,
	input  wire logic                  boost_allowed,
	input  wire logic                  save_after_off,
	// line outputs
	output logic                       src_enable,
	output logic                       gate_select,
	output logic                       reg_boost,
	output logic                       central_drive,
	output logic                       grey_save,
	output logic                       line_start,
	output logic [CW-1:0]              count
);
	import tlt_pkg::*;

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          src;
		logic          gate;
		logic          boost;
		logic          central;
		logic          save;
		logic          start;
	} tlt_line_state_type;

	tlt_line_state_type r_q, r_d;
	logic [CW-1:0] c8;

	always_comb begin
		r_d = r_q;
		r_d.start = 1'b0;
		c8 = r_q.cnt;
		if (!run) begin
			r_d = '0;
		end else if (tick) begin
			// restart at each line end [RULE24] [RULE23]
			if (r_q.cnt >= line_period) begin
				r_d.cnt = '0;
				r_d.start = 1'b1;
				r_d.boost = 1'b0;
				r_d.save = 1'b0;
			end else begin
				r_d.cnt = CW'(r_q.cnt + 1'b1);
			end
			c8 = r_d.cnt;
			if (c8 == CW'(src_on)) begin
				r_d.src = 1'b1; // [RULE8] [RULE7]
				r_d.save = 1'b0;
				r_d.central = (drive_mode == TLT_DRV_CENTRAL); // [RULE11]
			end
			if (c8 == CW'(switch_at) && drive_mode == TLT_DRV_SWITCH)
				r_d.central = 1'b1; // [RULE11]
			if (c8 == CW'(src_off)) begin
				r_d.src = 1'b0; // [RULE8]
				r_d.central = 1'b0;
				r_d.save = save_after_off; // [RULE10]
			end
			if (c8 == CW'(gate_on))
				r_d.gate = 1'b1; // [RULE9]
			if (c8 == CW'(gate_off))
				r_d.gate = 1'b0; // [RULE9]
			if (c8 == CW'(boost_at) && boost_allowed)
				r_d.boost = 1'b1; // [RULE12]
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			r_q <= '0;
		else
			r_q <= r_d;
	end

	assign src_enable    = r_q.src;
	assign gate_select   = r_q.gate;
	assign reg_boost     = r_q.boost;
	assign central_drive = r_q.central;
	assign grey_save     = r_q.save;
	assign line_start    = r_q.start;
	assign count         = r_q.cnt;
endmodule : tlt_line_gen
`default_nettype wire

//--- logic/tlt_line_timing.sv
// command decoder, setup store and line timing top with axi4-lite slave
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`include "tlt_map.svh"
`default_nettype none
// Summary of operation
// RULE1 - low nibble masks first source triplets
// RULE2 - high nibble masks last source triplets
// RULE3 - back porch lines equal value plus one
// RULE4 - twelve-bit front porch, one line prohibited
// RULE5 - nonzero test field floats all sources
// RULE6 - timing command takes seven parameter bytes
// RULE7 - counts use oscillator or divided pixel clock; here every pixel clock rising edge counts, undivided
// RULE8 - sources enabled between on and off
// RULE9 - gates selected between select and deselect
// RULE10 - common boost and grey save flags
// RULE11 - two-bit drive mode picks drive type
// RULE12 - regulator boost unless already held boosted
// RULE13 - host keeps switch count inside source window
// RULE14 - data condition command, one parameter byte
// RULE15 - row and column order reverse bits
// RULE16 - bit two drives oscillator output pin
// RULE17 - bit three picks address advance direction
// RULE18 - bit four picks colour order
// RULE19 - bits five, six pick transfer format
// RULE20 - bit seven picks external clock
// RULE21 - start address column then row
// RULE22 - end address column then row
// RULE23 - ten-bit line period bounds all counts
// RULE24 - per-line counter restarts each line
module tlt_line_timing #(
	parameter int N_SRC = 528,
	parameter int CW    = 10
) (
	// clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// axi4-lite write address
	input  wire logic [11:0]       s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	// axi4-lite write response
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// axi4-lite read address
	input  wire logic [11:0]       s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	// axi4-lite read data
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// clock pins
	input  wire logic              pixel_clock,
	input  wire logic              osc_clock_in_pin,
	input  wire logic              osc_tick,
	output logic                   osc_clock_out_pin_o,
	output logic                   osc_clock_out_pin_oe_n,
	// panel drive
	output logic [N_SRC-1:0]       src_hiz,
	output logic                   gate_select_level,
	output logic                   common_drive_boost,
	output logic                   reg_boost,
	output logic                   central_drive,
	output logic                   grey_save,
	output logic                   line_start,
	// display data options
	output logic                   row_reverse,
	output logic                   col_reverse,
	output logic                   advance_row,
	output logic                   colour_bgr,
	output logic                   two_transfers,
	output logic                   wide_first,
	output logic                   ext_clock_sel,
	output logic [7:0]             start_col,
	output logic [7:0]             start_row,
	output logic [7:0]             end_col,
	output logic [7:0]             end_row,
	output logic [7:0]             back_porch,
	output logic [11:0]            front_porch
);
	import tlt_pkg::*;

	localparam int NG = N_SRC / `TLT_GROUP_WIDTH;

	typedef struct packed {
		tlt_cmd_state_type cst;
		logic [7:0]  cmd;
		logic [3:0]  idx;
		logic [9:0]  period;
		logic [7:0]  hiz;
		logic [7:0]  bp;
		logic [11:0] fp;
		logic [2:0]  test;
		logic [7:0]  s_on;
		logic [7:0]  s_off;
		logic [7:0]  g_on;
		logic [7:0]  g_off;
		logic [3:0]  dflags;
		logic [7:0]  boost;
		logic [7:0]  sw;
		logic [7:0]  dcond;
		logic [7:0]  scol;
		logic [7:0]  srow;
		logic [7:0]  ecol;
		logic [7:0]  erow;
		logic [3:0]  ctrl;
		logic        aw_ok;
		logic [11:0] awa;
		logic        w_ok;
		logic [31:0] wd;
		logic        bv;
		logic [1:0]  br;
		logic        rv;
		logic [31:0] rd;
		logic [1:0]  rr;
		logic [1:0]  pix_s;
		logic [1:0]  osc_clock_in_pin_s;
		logic        pix_prev;
		logic        osc_clock_in_pin_prev;
		logic        src_hiz_all;
	} tlt_state_type;

	tlt_state_type r_q, r_d;

	logic        tick;
	logic        g_src, g_gate, g_boost, g_central, g_save, g_start;
	logic [CW-1:0] g_count;
	logic        wr_go;
	logic [7:0]  pbyte;

	// ------------------------------------------------------------
	// command and register decode
	// ------------------------------------------------------------
	always_comb begin
		r_d = r_q;
		pbyte = r_q.wd[7:0];
		wr_go = r_q.aw_ok && r_q.w_ok && !r_q.bv;
		// pin synchronisers
		r_d.pix_s = {r_q.pix_s[0], pixel_clock};
		r_d.osc_clock_in_pin_s = {r_q.osc_clock_in_pin_s[0], osc_clock_in_pin};
		r_d.pix_prev = r_q.pix_s[1];
		r_d.osc_clock_in_pin_prev = r_q.osc_clock_in_pin_s[1];
		// axi write channels, either order
		if (s_axi_awvalid && !r_q.aw_ok && !r_q.bv) begin
			r_d.aw_ok = 1'b1;
			r_d.awa = s_axi_awaddr;
		end
		if (s_axi_wvalid && !r_q.w_ok && !r_q.bv) begin
			r_d.w_ok = 1'b1;
			r_d.wd = s_axi_wdata;
		end
		if (r_q.bv && s_axi_bready)
			r_d.bv = 1'b0;
		if (wr_go) begin
			r_d.aw_ok = 1'b0;
			r_d.w_ok = 1'b0;
			r_d.bv = 1'b1;
			r_d.br = 2'b00;
			case (r_q.awa & 12'hffc)
			`TLT_OFS_CMD: begin
				r_d.cmd = pbyte;
				r_d.idx = 4'd0;
				case (pbyte)
				`TLT_CMD_SET_DISPLAY, `TLT_CMD_SET_TIMING,
				`TLT_CMD_SET_DATA, `TLT_CMD_START_ADDR,
				`TLT_CMD_END_ADDR:
					r_d.cst = TLT_PARAMS; // [RULE6]
				default:
					r_d.cst = TLT_IGNORE;
				endcase
			end
			`TLT_OFS_PARAM: begin
				if (r_q.cst == TLT_PARAMS) begin
					r_d.idx = r_q.idx + 4'd1;
					case (r_q.cmd)
					`TLT_CMD_SET_DISPLAY: begin
						case (r_q.idx)
						4'd0: begin
							r_d.period[9:8] = pbyte[1:0]; // [RULE23]
							r_d.fp[11:8] = pbyte[7:4]; // [RULE4]
						end
						4'd1: r_d.period[7:0] = pbyte; // [RULE23]
						4'd5: r_d.hiz = pbyte; // [RULE1] [RULE2]
						4'd6: r_d.bp = pbyte; // [RULE3]
						4'd7: r_d.fp[7:0] = pbyte; // [RULE4]
						4'd8: r_d.test = pbyte[2:0]; // [RULE5]
						default: ;
						endcase
						if (r_q.idx == `TLT_PARAMS_DISPLAY - 4'd1)
							r_d.cst = TLT_IDLE;
					end
					`TLT_CMD_SET_TIMING: begin
						case (r_q.idx)
						4'd0: r_d.s_on = pbyte; // [RULE6]
						4'd1: r_d.s_off = pbyte;
						4'd2: r_d.g_on = pbyte;
						4'd3: r_d.g_off = pbyte;
						4'd4: r_d.dflags = pbyte[3:0];
						4'd5: r_d.boost = pbyte;
						4'd6: r_d.sw = pbyte;
						default: ;
						endcase
						if (r_q.idx == `TLT_PARAMS_TIMING - 4'd1)
							r_d.cst = TLT_IDLE;
					end
					`TLT_CMD_SET_DATA: begin
						r_d.dcond = pbyte; // [RULE14]
						r_d.cst = TLT_IDLE;
					end
					`TLT_CMD_START_ADDR: begin
						if (r_q.idx == 4'd0)
							r_d.scol = pbyte; // [RULE21]
						else begin
							r_d.srow = pbyte; // [RULE21]
							r_d.cst = TLT_IDLE;
						end
					end
					default: begin
						if (r_q.idx == 4'd0)
							r_d.ecol = pbyte; // [RULE22]
						else begin
							r_d.erow = pbyte; // [RULE22]
							r_d.cst = TLT_IDLE;
						end
					end
					endcase
				end
			end
			`TLT_OFS_CTRL: begin
				if (s_axi_wstrb[0])
					r_d.ctrl = r_q.wd[3:0];
			end
			`TLT_OFS_STATUS, `TLT_OFS_SRC_HIZ, `TLT_OFS_LINE_CFG,
			`TLT_OFS_TIMING0, `TLT_OFS_TIMING1, `TLT_OFS_DATA_COND,
			`TLT_OFS_ADDR: ;
			default: r_d.br = 2'b10;
			endcase
		end
		// axi read
		if (r_q.rv && s_axi_rready)
			r_d.rv = 1'b0;
		if (s_axi_arvalid && !r_q.rv) begin
			r_d.rv = 1'b1;
			r_d.rr = 2'b00;
			case (s_axi_araddr & 12'hffc)
			`TLT_OFS_CMD:       r_d.rd = {24'h0, r_q.cmd};
			`TLT_OFS_PARAM:     r_d.rd = {28'h0, r_q.idx};
			`TLT_OFS_CTRL:      r_d.rd = {28'h0, r_q.ctrl};
			`TLT_OFS_STATUS:    r_d.rd = {13'h0, r_q.cst, g_save,
				g_central, g_boost, g_gate, g_src, 1'b0,
				g_count};
			`TLT_OFS_SRC_HIZ:   r_d.rd = {21'h0, r_q.test, r_q.hiz};
			`TLT_OFS_LINE_CFG:  r_d.rd = {2'h0, r_q.fp, r_q.bp,
				r_q.period};
			`TLT_OFS_TIMING0:   r_d.rd = {r_q.g_off, r_q.g_on,
				r_q.s_off, r_q.s_on};
			`TLT_OFS_TIMING1:   r_d.rd = {12'h0, r_q.dflags, r_q.sw,
				r_q.boost};
			`TLT_OFS_DATA_COND: r_d.rd = {24'h0, r_q.dcond};
			`TLT_OFS_ADDR:      r_d.rd = {r_q.erow, r_q.ecol,
				r_q.srow, r_q.scol};
			default: begin
				r_d.rd = 32'h0;
				r_d.rr = 2'b10;
			end
			endcase
		end
		r_d.src_hiz_all = (r_q.test != 3'b000); // [RULE5]
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r_q <= '0;
			r_q.cst <= TLT_IDLE;
			r_q.period <= `TLT_RST_LINE_PERIOD;
			r_q.bp <= `TLT_RST_BACK_PORCH;
			r_q.fp <= `TLT_RST_FRONT_PORCH;
			r_q.s_on <= `TLT_RST_SRC_ON;
			r_q.s_off <= `TLT_RST_SRC_OFF;
			r_q.g_on <= `TLT_RST_GATE_ON;
			r_q.g_off <= `TLT_RST_GATE_OFF;
			r_q.boost <= `TLT_RST_BOOST;
			r_q.sw <= `TLT_RST_SWITCH;
			r_q.ecol <= `TLT_RST_END_COL;
			r_q.erow <= `TLT_RST_END_ROW;
		end else begin
			r_q <= r_d;
		end
	end

	// ------------------------------------------------------------
	// timing clock choice and line generator
	// ------------------------------------------------------------
	// pixel clock or external osc edge, else internal tick [RULE7] [RULE20]
	always_comb begin
		if (r_q.ctrl[`TLT_CTRL_PIXCLK])
			tick = r_q.pix_s[1] && !r_q.pix_prev;
		else if (r_q.dcond[7])
			tick = r_q.osc_clock_in_pin_s[1] && !r_q.osc_clock_in_pin_prev;
		else
			tick = osc_tick;
	end

	tlt_line_gen #(
		.CW (CW)
	) u_line (
		.aclk           (aclk),
		.aresetn        (aresetn),
		.tick           (tick),
		.run            (r_q.ctrl[`TLT_CTRL_RUN]),
		.line_period    (CW'(r_q.period)),
		.src_on         (r_q.s_on),
		.src_off        (r_q.s_off),
		.gate_on        (r_q.g_on),
		.gate_off       (r_q.g_off),
		.boost_at       (r_q.boost),
		.switch_at      (r_q.sw),
		.drive_mode     (tlt_drive_mode_type'(r_q.dflags[1:0])),
		.boost_allowed  (!r_q.ctrl[`TLT_CTRL_REG_BOOSTED]), // [RULE12]
		.save_after_off (r_q.dflags[2]), // [RULE10]
		.src_enable     (g_src),
		.gate_select    (g_gate),
		.reg_boost      (g_boost),
		.central_drive  (g_central),
		.grey_save      (g_save),
		.line_start     (g_start),
		.count          (g_count)
	);

	// ------------------------------------------------------------
	// source high impedance masks
	// ------------------------------------------------------------
	for (genvar g = 0; g < NG; g++) begin : g_hiz
		localparam int GL = g;
		localparam int GH = NG - 1 - g;
		logic lo, hi;
		assign lo = r_q.hiz[`TLT_HIZ_EN_BIT] &&
			(GL <= int'(r_q.hiz[2:0])); // [RULE1]
		assign hi = r_q.hiz[`TLT_HIZ_EN_BIT + 4] &&
			(GH <= int'(r_q.hiz[6:4])); // [RULE2]
		assign src_hiz[3*g +: 3] = {3{lo || hi || r_q.src_hiz_all ||
			!g_src}}; // [RULE8] [RULE5]
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// no new write accepted while a response is pending
	assign s_axi_awready = !r_q.aw_ok && !r_q.bv;
	assign s_axi_wready  = !r_q.w_ok && !r_q.bv;
	assign s_axi_bvalid  = r_q.bv;
	assign s_axi_bresp   = r_q.br;
	assign s_axi_arready = !r_q.rv;
	assign s_axi_rvalid  = r_q.rv;
	assign s_axi_rdata   = r_q.rd;
	assign s_axi_rresp   = r_q.rr;

	assign osc_clock_out_pin_o    = osc_tick;
	assign osc_clock_out_pin_oe_n = !r_q.dcond[2]; // [RULE16]
	assign gate_select_level  = g_gate;
	assign common_drive_boost = r_q.dflags[3] &&
		r_q.ctrl[`TLT_CTRL_COM_PWR] && g_src; // [RULE10]
	assign reg_boost     = g_boost;
	assign central_drive = g_central;
	assign grey_save     = g_save;
	assign line_start    = g_start;
	assign row_reverse   = r_q.dcond[0]; // [RULE15]
	assign col_reverse   = r_q.dcond[1]; // [RULE15]
	assign advance_row   = r_q.dcond[3]; // [RULE17]
	assign colour_bgr    = r_q.dcond[4]; // [RULE18]
	assign two_transfers = r_q.dcond[5]; // [RULE19]
	assign wide_first    = r_q.dcond[6]; // [RULE19]
	assign ext_clock_sel = r_q.dcond[7]; // [RULE20]
	assign start_col     = r_q.scol;
	assign start_row     = r_q.srow;
	assign end_col       = r_q.ecol;
	assign end_row       = r_q.erow;
	assign back_porch    = r_q.bp; // [RULE3]
	assign front_porch   = r_q.fp; // [RULE4]
endmodule : tlt_line_timing
`default_nettype wire

//--- bench/tlt_checker.sv
// port assertions for the line timing block
`default_nettype none
module tlt_checker #(
	parameter int N_SRC = 528
) (
	// watched ports
	input wire logic             aclk,
	input wire logic             aresetn,
	input wire logic             s_axi_awvalid,
	input wire logic             s_axi_awready,
	input wire logic             s_axi_wvalid,
	input wire logic             s_axi_wready,
	input wire logic [1:0]       s_axi_bresp,
	input wire logic             s_axi_bvalid,
	input wire logic             s_axi_bready,
	input wire logic             s_axi_arvalid,
	input wire logic             s_axi_arready,
	input wire logic [31:0]      s_axi_rdata,
	input wire logic             s_axi_rvalid,
	input wire logic             s_axi_rready,
	input wire logic [N_SRC-1:0] src_hiz,
	input wire logic             line_start,
	input wire logic [7:0]       end_col,
	input wire logic [7:0]       end_row
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write response missing");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_write_refuse: assert property (s_axi_bvalid |->
		!s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid)
		else $error("read data late");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
	a_line_pulse: assert property (line_start |=> !line_start)
		else $error("line start wider than one cycle");
	a_hiz_reset: assert property (!$past(aresetn) |-> &src_hiz)
		else $error("sources driven after reset");
	a_end_reset: assert property ($rose(aresetn) |->
		end_col == 8'haf && end_row == 8'hdb)
		else $error("end address reset value wrong");
endmodule : tlt_checker
`default_nettype wire

//--- bench/tlt_clock_source.sv
// oscillator tick and pixel clock source for the timing block
`default_nettype none
module tlt_clock_source (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// timing clocks
	output logic     osc_tick,
	output logic     pixel_clock
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] div_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_q <= 2'h0;
		end else begin
			div_q <= div_q + 2'h1;
		end
	end
	// tick every second cycle, pixel clock at quarter rate
	assign osc_tick = div_q[0];
	assign pixel_clock = div_q[1];
endmodule : tlt_clock_source
`default_nettype wire

//--- bench/tft_line_timing_config_test.sv
// self-checking bench for the line timing block
`include "tlt_map.svh"
`default_nettype none
module tft_line_timing_config_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int NS = 528;
	logic aclk = 0, aresetn = 0;
	logic [11:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, rd_q, seed = 50;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, osc_tick, pix, oe_n;
	logic [1:0] bresp, rresp, rs_q;
	logic [NS-1:0] src_hiz;
	logic gate, boost, central, save, lstart, cdb, osc_o;
	logic rowr, colr, advr, bgr, two, wide, ext;
	logic [7:0] scol, srow, ecol, erow, bp;
	logic [11:0] fp;
	int n_errors = 0, checks_done = 0, cycles = 0;
	tlt_clock_source u_src (.aclk(aclk), .aresetn(aresetn),
		.osc_tick(osc_tick), .pixel_clock(pix));
	tlt_line_timing #(.N_SRC(NS)) u_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .pixel_clock(pix),
		.osc_clock_in_pin(pix), .osc_tick(osc_tick),
		.osc_clock_out_pin_o(osc_o), .osc_clock_out_pin_oe_n(oe_n),
		.src_hiz(src_hiz), .gate_select_level(gate),
		.common_drive_boost(cdb), .reg_boost(boost),
		.central_drive(central), .grey_save(save), .line_start(lstart),
		.row_reverse(rowr), .col_reverse(colr), .advance_row(advr),
		.colour_bgr(bgr), .two_transfers(two), .wide_first(wide),
		.ext_clock_sel(ext), .start_col(scol), .start_row(srow),
		.end_col(ecol), .end_row(erow), .back_porch(bp), .front_porch(fp));
	// ----
	// clock, timeout and helpers
	// ----
	always #25 aclk = ~aclk;
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			n_errors = n_errors + 1;
			finish_test();
		end
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [NS-1:0] hiz_exp(logic [7:0] p6, logic [2:0] t);
		logic [NS-1:0] m;
		m = '0;
		for (int i = 0; i < 24; i++) begin
			if (p6[3] && i < 3 * (p6[2:0] + 1)) m[i] = 1'b1;
			if (p6[7] && i < 3 * (p6[6:4] + 1)) m[NS-1-i] = 1'b1;
		end
		return (t != 3'b000) ? '1 : m;
	endfunction : hiz_exp
	task automatic chk(string what, logic [NS-1:0] exp, logic [NS-1:0] got);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(logic [11:0] a, logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
	endtask : wr
	task automatic rd(logic [11:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rd_q = rdata;
		rs_q = rresp;
		rready <= 1'b0;
	endtask : rd
	task automatic send(logic [7:0] c, logic [7:0] p[$]);
		wr(`TLT_OFS_CMD, {24'h0, c});
		foreach (p[i]) wr(`TLT_OFS_PARAM, {24'h0, p[i]});
		@(posedge aclk);
	endtask : send
	task automatic wait_gate();
		while (lstart !== 1'b1) @(posedge aclk);
		while (gate !== 1'b1) @(posedge aclk);
		repeat (2) @(posedge aclk);
	endtask : wait_gate
	task automatic finish_test();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : finish_test
	// ----
	// main sequence
	// ----
	initial begin
		logic [7:0] v, c, r, h, a, b, f;
		logic [2:0] t;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk("end col", `TLT_RST_END_COL, ecol);
		chk("back porch", `TLT_RST_BACK_PORCH, bp);
		chk("front porch", `TLT_RST_FRONT_PORCH, fp);
		rd(12'h100);
		chk("unmapped resp", 2'b10, rs_q);
		chk("unmapped data", 0, rd_q);
		$display("test reset done");
		for (int k = 0; k < 8; k++) begin
			v = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : 8'(rnd());
			send(`TLT_CMD_SET_DATA, '{v});
			chk("data", {v[7:3], v[1:0]},
				{ext, wide, two, bgr, advr, colr, rowr});
			chk("osc pin enable", !v[2], oe_n);
		end
		send(8'h31, '{8'h5a});
		chk("ignored", {v[7:3], v[1:0]},
			{ext, wide, two, bgr, advr, colr, rowr});
		send(`TLT_CMD_SET_DATA, '{8'h00});
		$display("test data condition done");
		for (int k = 0; k < 4; k++) begin
			c = 8'(rnd() % 176);
			r = 8'(rnd() % 220);
			send(`TLT_CMD_START_ADDR, '{c, r});
			chk("start", {c, r}, {scol, srow});
			send(`TLT_CMD_END_ADDR, '{8'haf - c, 8'hdb - r});
			chk("end", {8'haf - c, 8'hdb - r}, {ecol, erow});
		end
		$display("test address done");
		wr(`TLT_OFS_CTRL, 32'h1);
		rd(`TLT_OFS_CTRL);
		chk("ctrl", 4'h1, rd_q[3:0]);
		// on 2, off 40, gate 4..30, switch 3 inside source window
		for (int m = 0; m < 3; m++) begin
			send(`TLT_CMD_SET_TIMING, '{8'h02, 8'h28, 8'h04, 8'h1e,
				8'(m), 8'h08, 8'h03});
			wait_gate();
			chk("central drive", m != 2, central);
		end
		while (lstart !== 1'b1) @(posedge aclk);
		@(posedge aclk);
		chk("hiz before on", '1, src_hiz);
		chk("gate before on", 0, gate);
		repeat (20) @(posedge aclk);
		chk("reg boost", 1, boost);
		send(`TLT_CMD_SET_TIMING, '{8'h02, 8'h28, 8'h04, 8'h1e,
			8'h0c, 8'h08, 8'h03});
		wr(`TLT_OFS_CTRL, 32'hd);
		wait_gate();
		repeat (12) @(posedge aclk);
		chk("boost held", 0, boost);
		chk("common boost", 1, cdb);
		repeat (80) @(posedge aclk);
		chk("grey save", 1, save);
		wr(`TLT_OFS_CTRL, 32'h3);
		$display("test line timing done");
		for (int k = 0; k < 5; k++) begin
			h = (k == 0) ? 8'h88 : (k == 1) ? 8'hff : 8'(rnd());
			a = 8'(rnd());
			b = 8'(rnd());
			f = 8'(rnd()) | 8'h01;
			t = (k == 4) ? 3'(rnd()) | 3'b001 : 3'b000;
			send(`TLT_CMD_SET_DISPLAY, '{{a[7:4], 4'h0}, 8'h3f, 8'h00, 8'h00,
				8'h00, h, b, f, {5'h00, t}});
			wait_gate();
			chk("src hiz", hiz_exp(h, t), src_hiz);
			chk("back porch", b, bp);
			chk("front porch", {a[7:4], f}, fp);
		end
		$display("test display setup done");
		finish_test();
	end
endmodule : tft_line_timing_config_test
bind tlt_line_timing tlt_checker #(.N_SRC(N_SRC)) u_chk (.aclk, .aresetn,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
	.src_hiz, .line_start, .end_col, .end_row);
`default_nettype wire
